//--- sim/csr_chk.sv
`timescale 1ns/1ps
// bus handshakes and primitive outputs of the reconfiguration controller
module csr_chk (
   // clock and reset
   input wire mclk,
   input wire rst,
   // bus
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   // primitive side
   input wire prim_reset_r,
   input wire prim_cfg_valid_r,
   input wire [7:0] prim_div_r,
   input wire [7:0] prim_mul_r,
   input wire [9:0] prim_frac_r,
   input wire prim_frac_en_r
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // ready strobes are single-cycle answers to a held request
   a_aw_pulse: assert property (
      s_axi_awready |=> !s_axi_awready) else $error("awready too long");
   a_ar_cause: assert property (
      s_axi_arready |-> s_axi_arvalid) else $error("arready without arvalid");
   a_w_cause: assert property (
      s_axi_wready |-> s_axi_wvalid) else $error("wready without wvalid");
   a_err_data: assert property (
      s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
      else $error("error read with data");
   a_resp_code: assert property (
      s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
      else $error("illegal write response");
   // reset must leave the primitive on the default setting, running
   a_reset_dflt: assert property (disable iff (1'h0) rst |=>
      prim_div_r == 8'h00 && prim_mul_r == 8'h0A && prim_frac_r == 10'h101
      && !prim_frac_en_r && !prim_reset_r) else $error("reset fields wrong");
   a_frac_limit: assert property (
      prim_frac_r <= 10'd875) else $error("fraction out of range");
   a_cfg_pulse: assert property (
      prim_cfg_valid_r |=> !prim_cfg_valid_r) else $error("apply pulse long");
   a_release: assert property (
      $rose(prim_cfg_valid_r) |-> ##[0:1] !prim_reset_r)
      else $error("primitive not released after apply");
endmodule

bind csr_reconfig csr_chk u_csr_chk (
   .mclk(mclk), .rst(rst), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .prim_reset_r(prim_reset_r),
   .prim_cfg_valid_r(prim_cfg_valid_r), .prim_div_r(prim_div_r),
   .prim_mul_r(prim_mul_r), .prim_frac_r(prim_frac_r),
   .prim_frac_en_r(prim_frac_en_r));

//--- sim/csr_prim_model.sv
`timescale 1ns/1ps
// behavioural clock primitive: loses lock in reset, relocks after a delay
module csr_prim_model #(
   parameter FAST = 3,
   parameter SLOW = 12
) (
   // clock
   input wire mclk,
   // primitive control
   input wire prim_reset_r,
   input wire slow,
   // lock indication
   output reg prim_locked
);
   reg [4:0] cnt_r = 5'h00;
   // slow relock must stay under the controller timeout to be seen as lock
   always @(posedge mclk) begin
      if (prim_reset_r) begin
         cnt_r <= 5'h00;
         prim_locked <= 1'h0;
      end else if (cnt_r < (slow ? SLOW : FAST)) begin
         cnt_r <= cnt_r + 5'h01;
         prim_locked <= 1'h0;
      end else begin
         prim_locked <= 1'h1;
      end
   end
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ps
`include "csr_map.vh"
module testbench;
   reg mclk = 1'h0;
   reg rst = 1'h1;
   reg [11:0] awaddr = 12'h000, araddr = 12'h000;
   reg [31:0] wdata = 32'h0, rd;
   reg awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, slow = 1'h0;
   reg [1:0] rs;
   wire awready, wready, bvalid, arready, rvalid, locked, p_rst, p_cv, p_uu;
   wire p_fe;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [7:0] p_div, p_mul;
   wire [9:0] p_frac;
   wire [31:0] pw = {5'h00, p_fe, p_frac, p_mul, p_div};
   integer err_total = 0, n_compared = 0, k;
   always #2 mclk = ~mclk;
   // short lock timeout keeps the run brief; responses always accepted
   csr_reconfig #(.LOCK_TIMEOUT(16'h0014)) u_csr_reconfig (
      .mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
      .prim_locked(locked), .prim_reset_r(p_rst), .prim_cfg_valid_r(p_cv),
      .prim_use_user_r(p_uu), .prim_div_r(p_div), .prim_mul_r(p_mul),
      .prim_frac_r(p_frac), .prim_frac_en_r(p_fe));
   csr_prim_model u_csr_prim_model (.mclk(mclk), .prim_reset_r(p_rst),
      .slow(slow), .prim_locked(locked));
   task give_verdict;
      begin
         $display("errors %0d compares %0d", err_total, n_compared);
         if (err_total == 0 && n_compared > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
      begin
         n_compared = n_compared + 1;
         if (e !== g) begin
            $display("BAD %0s exp %h got %h", nm, e, g);
            err_total = err_total + 1;
         end
      end
   endtask
   task hang;
      begin
         $display("BAD handshake exp done got timeout");
         err_total = err_total + 1;
         give_verdict;
      end
   endtask
   // requests held until their ready edge; a soft reset may eat the answer
   task wr(input [11:0] a, input [31:0] d, output [1:0] r);
      integer i;
      begin
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'h1;
         wvalid <= 1'h1;
         i = 0;
         r = 2'h3;
         while (i < 40) begin
            @(posedge mclk);
            i = i + 1;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) begin
               r = bresp;
               i = 99;
            end
         end
         if (i != 99 && a != `CSR_OFF_SOFT_RESET) hang;
      end
   endtask
   task rdr(input [11:0] a, output [31:0] d, output [1:0] r);
      integer i;
      begin
         araddr <= a;
         arvalid <= 1'h1;
         i = 0;
         while (i < 40) begin
            @(posedge mclk);
            i = i + 1;
            if (arready) arvalid <= 1'h0;
            if (rvalid) begin
               d = rdata;
               r = rresp;
               i = 99;
            end
         end
         if (i != 99) hang;
      end
   endtask
   // status polling bounded well above the lock timeout
   task wait_lock;
      begin
         k = 0;
         rd = 32'h0;
         while (k < 30 && rd[0] !== 1'h1) begin
            rdr(`CSR_OFF_STATUS, rd, rs);
            k = k + 1;
         end
         chk("lockstat", 32'h1, rd);
      end
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'h0;
      repeat (8) @(posedge mclk);
      rdr(`CSR_OFF_CFG0, rd, rs);
      chk("cfg0", `CSR_CFG0_DEFAULT, rd);
      chk("prim", `CSR_CFG0_DEFAULT, pw);
      wait_lock;
      rdr(12'h100, rd, rs);
      chk("unmapped", 32'h2, {30'h0, rs});
      wr(12'h100, 32'h00000001, rs);
      chk("wrerr", 32'h2, {30'h0, rs});
      // values chosen to keep the oscillator inside its range
      wr(`CSR_OFF_CFG0, 32'h047D0805, rs);
      chk("wresp", 32'h0, {30'h0, rs});
      rdr(`CSR_OFF_CFG0, rd, rs);
      chk("cfg0", 32'h047D0805, rd);
      wr(`CSR_OFF_CFG0, 32'h07840805, rs);
      rdr(`CSR_OFF_CFG0, rd, rs);
      chk("fraction", 32'h047D0805, rd);
      wait_lock;
      wr(`CSR_OFF_TRIGGER, `CSR_TRIG_START, rs);
      rdr(`CSR_OFF_STATUS, rd, rs);
      chk("busystat", 32'h0, rd);
      chk("primrst", 32'h1, {31'h0, p_rst});
      wr(`CSR_OFF_TRIGGER, `CSR_TRIG_LOAD, rs);
      wait_lock;
      chk("prim", 32'h047D0805, pw);
      chk("useuser", 32'h1, {31'h0, p_uu});
      // restore runs against a slowly relocking primitive
      slow <= 1'h1;
      wr(`CSR_OFF_TRIGGER, `CSR_TRIG_RESTORE, rs);
      wr(`CSR_OFF_TRIGGER, `CSR_TRIG_IDLE, rs);
      wait_lock;
      chk("prim", `CSR_CFG0_DEFAULT, pw);
      chk("useuser", 32'h0, {31'h0, p_uu});
      // fraction disabled: the stored fraction must not reach the primitive
      wr(`CSR_OFF_CFG0, 32'h007D0A02, rs);
      wait_lock;
      wr(`CSR_OFF_TRIGGER, `CSR_TRIG_START, rs);
      wr(`CSR_OFF_TRIGGER, `CSR_TRIG_LOAD, rs);
      wait_lock;
      chk("prim", 32'h00000A02, pw);
      // restore is also taken while the primitive waits for the load code
      wr(`CSR_OFF_TRIGGER, `CSR_TRIG_START, rs);
      wr(`CSR_OFF_TRIGGER, `CSR_TRIG_RESTORE, rs);
      wr(`CSR_OFF_TRIGGER, `CSR_TRIG_IDLE, rs);
      wait_lock;
      chk("prim", `CSR_CFG0_DEFAULT, pw);
      wr(`CSR_OFF_SOFT_RESET, `CSR_SOFT_RESET_KEY, rs);
      repeat (3) @(posedge mclk);
      rdr(`CSR_OFF_CFG0, rd, rs);
      chk("cfg0", `CSR_CFG0_DEFAULT, rd);
      give_verdict;
   end
endmodule

//--- src/csr_lock_wait.v
`timescale 1ns/1ps
`include "csr_map.vh"
// waits for the primitive lock after release, with a bounded timeout
module csr_lock_wait #(
   parameter TIMEOUT = `CSR_LOCK_TIMEOUT
) (
   // clock and reset
   input wire mclk,
   input wire rst,
   // control
   input wire start,
   input wire lock_sync,
   output reg done_r
);
   reg [15:0] cnt_r;
   reg busy_r;
   // timeout keeps the controller from hanging on a primitive that never locks
   always @(posedge mclk) begin
      if (rst) begin
         cnt_r <= 16'h0000;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (start) begin
            cnt_r <= 16'h0000;
            busy_r <= 1'b1;
         end else if (busy_r) begin
            cnt_r <= cnt_r + 16'h0001;
            if (lock_sync || cnt_r == TIMEOUT) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end
         end
      end
   end
endmodule

//--- src/csr_map.vh
`ifndef CSR_MAP_VH
`define CSR_MAP_VH
`define CSR_OFF_SOFT_RESET 12'h000
`define CSR_OFF_STATUS 12'h004
`define CSR_OFF_CFG0 12'h200
`define CSR_OFF_TRIGGER 12'h25C
`define CSR_SOFT_RESET_KEY 32'h0000000A
`define CSR_CFG0_DEFAULT 32'h01010A00
`define CSR_TRIG_START 32'h00000007
`define CSR_TRIG_LOAD 32'h00000002
`define CSR_TRIG_RESTORE 32'h00000004
`define CSR_TRIG_IDLE 32'h00000000
`define CSR_DIV_LSB 0
`define CSR_DIV_MSB 7
`define CSR_MUL_LSB 8
`define CSR_MUL_MSB 15
`define CSR_FRAC_LSB 16
`define CSR_FRAC_MSB 25
`define CSR_FRAC_EN_BIT 26
`define CSR_FRAC_MAX 10'd875
`define CSR_CFG0_MASK 32'h07FFFFFF
`define CSR_LOCK_TIMEOUT 16'd4000
`endif

//--- src/csr_reconfig.v
`timescale 1ns/1ps
`include "csr_map.vh"
// register-based reconfiguration controller for the clock synthesizer
module csr_reconfig #(
   parameter DYN_RECONFIG = 1,
   parameter SPREAD_SPECTRUM = 0,
   // phase/duty space is not built; its offsets answer slverr
   parameter PHASE_DUTY_CFG = 0,
   parameter [31:0] DEFAULT_CFG0 = `CSR_CFG0_DEFAULT,
   parameter LOCK_TIMEOUT = `CSR_LOCK_TIMEOUT
) (
   // clock and reset
   input wire mclk,
   input wire rst,
   // axi4-lite write address
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // clock synthesizer primitive
   input wire prim_locked,
   output reg prim_reset_r,
   output reg prim_cfg_valid_r,
   output reg prim_use_user_r,
   output reg [7:0] prim_div_r,
   output reg [7:0] prim_mul_r,
   output reg [9:0] prim_frac_r,
   output reg prim_frac_en_r
);
   localparam ST_IDLE = 3'd0;
   localparam ST_ARMED = 3'd1;
   localparam ST_LOAD = 3'd2;
   localparam ST_WAIT = 3'd3;
   localparam ST_RESTORE = 3'd4;

   // register port only when reconfig chosen and spread spectrum is not
   localparam ENABLED = (DYN_RECONFIG != 0) && (SPREAD_SPECTRUM == 0);

   // byte-lane merge used by the configuration register only; trigger takes the full word
   function [31:0] merge;
      input [31:0] old;
      input [31:0] dat;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = dat[i*8 +: 8];
            end
         end
      end
   endfunction

   reg [31:0] cfg0_r; // user configuration
   reg [31:0] trig_r;
   reg [2:0] state_r;
   reg busy_r;
   reg lock_m_r;
   reg lock_s_r;
   reg soft_rst_r;
   reg [11:0] waddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg have_aw_r;
   reg have_w_r;
   reg wait_start_r;
   wire wait_done;
   wire blk_rst;
   wire do_write;
   wire [31:0] cfg0_nxt;
   wire [9:0] frac_in;

   assign blk_rst = rst | soft_rst_r;
   assign do_write = have_aw_r && have_w_r && !s_axi_bvalid;
   assign cfg0_nxt = merge(cfg0_r, wdata_r, wstrb_r) & `CSR_CFG0_MASK;
   assign frac_in = cfg0_nxt[`CSR_FRAC_MSB:`CSR_FRAC_LSB];

   // lock arrives from the primitive's domain, two flops first
   always @(posedge mclk) begin
      if (rst) begin
         lock_m_r <= 1'b0;
         lock_s_r <= 1'b0;
      end else begin
         lock_m_r <= prim_locked;
         lock_s_r <= lock_m_r;
      end
   end

   csr_lock_wait #(
      .TIMEOUT(LOCK_TIMEOUT)
   ) u_wait (
      .mclk(mclk),
      .rst(blk_rst),
      .start(wait_start_r),
      .lock_sync(lock_s_r),
      .done_r(wait_done)
   );

   // write channel: address and data captured independently
   always @(posedge mclk) begin
      if (blk_rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         have_aw_r <= 1'b0;
         have_w_r <= 1'b0;
         waddr_r <= 12'h000;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
      end else begin
         s_axi_awready <= !have_aw_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !have_w_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awready && s_axi_awvalid) begin
            have_aw_r <= 1'b1;
            waddr_r <= s_axi_awaddr;
         end
         if (s_axi_wready && s_axi_wvalid) begin
            have_w_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            have_aw_r <= 1'b0;
            have_w_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // unmapped or disabled space answers slverr
            if (!ENABLED) begin
               s_axi_bresp <= 2'b10;
            end else if (waddr_r == `CSR_OFF_SOFT_RESET ||
                         waddr_r == `CSR_OFF_CFG0 ||
                         waddr_r == `CSR_OFF_TRIGGER) begin
               s_axi_bresp <= 2'b00;
            end else begin
               s_axi_bresp <= 2'b10;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // soft reset pulse; it is recomputed every cycle from the write so it spans one cycle
   always @(posedge mclk) begin
      if (rst) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= ENABLED && do_write &&
            waddr_r == `CSR_OFF_SOFT_RESET &&
            wstrb_r == 4'hF &&
            wdata_r == `CSR_SOFT_RESET_KEY;
      end
   end

   // configuration and trigger registers
   always @(posedge mclk) begin
      if (blk_rst) begin
         cfg0_r <= DEFAULT_CFG0;
         trig_r <= `CSR_TRIG_IDLE;
      end else if (ENABLED && do_write) begin
         if (waddr_r == `CSR_OFF_CFG0) begin
            // out-of-range fraction is refused, field keeps its value
            if (frac_in > `CSR_FRAC_MAX) begin
               cfg0_r <= {cfg0_nxt[31:26], cfg0_r[25:16], cfg0_nxt[15:0]};
            end else begin
               cfg0_r <= cfg0_nxt;
            end
         end else if (waddr_r == `CSR_OFF_TRIGGER) begin
            trig_r <= wdata_r;
         end
      end
   end

   // reconfiguration sequencer
   always @(posedge mclk) begin
      if (blk_rst) begin
         state_r <= ST_IDLE;
         busy_r <= 1'b0;
         wait_start_r <= 1'b0;
         prim_reset_r <= 1'b0;
         prim_cfg_valid_r <= 1'b0;
         prim_use_user_r <= 1'b0;
         prim_div_r <= DEFAULT_CFG0[`CSR_DIV_MSB:`CSR_DIV_LSB];
         prim_mul_r <= DEFAULT_CFG0[`CSR_MUL_MSB:`CSR_MUL_LSB];
         prim_frac_r <= DEFAULT_CFG0[`CSR_FRAC_MSB:`CSR_FRAC_LSB];
         prim_frac_en_r <= DEFAULT_CFG0[`CSR_FRAC_EN_BIT];
      end else begin
         wait_start_r <= 1'b0;
         prim_cfg_valid_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (ENABLED && do_write && waddr_r == `CSR_OFF_TRIGGER) begin
                  if (wdata_r == `CSR_TRIG_START) begin
                     state_r <= ST_ARMED;
                     busy_r <= 1'b1;
                     prim_reset_r <= 1'b1;
                  end else if (wdata_r == `CSR_TRIG_RESTORE) begin
                     state_r <= ST_RESTORE;
                     busy_r <= 1'b1;
                     prim_reset_r <= 1'b1;
                  end
               end
            end
            ST_ARMED: begin
               // primitive held in reset until software writes the load code, or the restore code and then the idle code
               if (do_write && waddr_r == `CSR_OFF_TRIGGER &&
                   wdata_r == `CSR_TRIG_LOAD) begin
                  state_r <= ST_LOAD;
               end else if (do_write && waddr_r == `CSR_OFF_TRIGGER &&
                   wdata_r == `CSR_TRIG_RESTORE) begin
                  // restore is honoured here too, not only from idle
                  state_r <= ST_RESTORE;
               end
            end
            ST_LOAD: begin
               // fraction disabled drives a zero fraction; divider and multiplier still come from cfg0
               prim_use_user_r <= cfg0_r[`CSR_FRAC_EN_BIT] |
                  (cfg0_r[25:0] != DEFAULT_CFG0[25:0]);
               prim_div_r <= cfg0_r[`CSR_DIV_MSB:`CSR_DIV_LSB];
               prim_mul_r <= cfg0_r[`CSR_MUL_MSB:`CSR_MUL_LSB];
               prim_frac_r <= cfg0_r[`CSR_FRAC_EN_BIT] ?
                  cfg0_r[`CSR_FRAC_MSB:`CSR_FRAC_LSB] : 10'h000;
               prim_frac_en_r <= cfg0_r[`CSR_FRAC_EN_BIT];
               prim_cfg_valid_r <= 1'b1;
               prim_reset_r <= 1'b0;
               wait_start_r <= 1'b1;
               state_r <= ST_WAIT;
            end
            ST_RESTORE: begin
               // restore waits for the idle code before releasing
               if (do_write && waddr_r == `CSR_OFF_TRIGGER &&
                   wdata_r == `CSR_TRIG_IDLE) begin
                  prim_use_user_r <= 1'b0;
                  prim_div_r <= DEFAULT_CFG0[`CSR_DIV_MSB:`CSR_DIV_LSB];
                  prim_mul_r <= DEFAULT_CFG0[`CSR_MUL_MSB:`CSR_MUL_LSB];
                  prim_frac_r <= DEFAULT_CFG0[`CSR_FRAC_MSB:`CSR_FRAC_LSB];
                  prim_frac_en_r <= DEFAULT_CFG0[`CSR_FRAC_EN_BIT];
                  prim_cfg_valid_r <= 1'b1;
                  prim_reset_r <= 1'b0;
                  wait_start_r <= 1'b1;
                  state_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (wait_done) begin
                  busy_r <= 1'b0;
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // read channel; reset register and unknown space read zero with slverr
   always @(posedge mclk) begin
      if (blk_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arready && s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h00000000;
            if (!ENABLED) begin
               s_axi_rresp <= 2'b10;
            end else if (s_axi_araddr == `CSR_OFF_STATUS) begin
               s_axi_rdata <= {31'h00000000, lock_s_r & !busy_r};
            end else if (s_axi_araddr == `CSR_OFF_CFG0) begin
               s_axi_rdata <= cfg0_r;
            end else if (s_axi_araddr == `CSR_OFF_TRIGGER) begin
               s_axi_rdata <= trig_r;
            end else begin
               s_axi_rresp <= 2'b10;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule
